// ### rtl/twh_pkg.sv
// Constants for the two-wire port host sequencer
// Operation
// R1 - The port offers master and slave, transmit and receive modes.
// R2 - Modes may be mixed in one application, switching per transfer.
// R3 - Addressed and sent data by another master, the port is slave receiver.
// R4 - Software alone decides which modes are allowed.
// R5 - Direction bit high on the data line means read.
// R6 - Direction bit low on the data line means write.
// R7 - Acknowledge is a low data line in the acknowledge slot.
// R8 - Not-acknowledge is a high data line in the acknowledge slot.
// R9 - Each data packet is one eight-bit byte plus acknowledge slot.
// R10 - At each step the port sets its flag and posts a status code.
// R11 - The transfer stays suspended while the flag is set.
// R12 - Software acts on the status code before clearing the flag.
// R13 - Status is masked with F8 before comparing codes.
// R14 - After address with write, any code but address-acked is an error.
// R15 - Send a byte: load data, then write control with flag and enable.
// R16 - The flag rises again only after byte and acknowledge have passed.
// R17 - A stop goes out on a control write with flag, enable and stop.
// R18 - After a start the flag is set with the start-sent code.
// R19 - A byte sent and acknowledged has its own status code.
// R20 - A data write while the flag is low is dropped and flags collision.
// R21 - Flag and status live in system clock registers, flag reset clears.
package twh_pkg;
  // ****************
  // Port register map
  // ****************
  localparam logic [1:0] DEV_CTRL_IDX = 2'h0;
  localparam logic [1:0] DEV_STAT_IDX = 2'h1;
  localparam logic [1:0] DEV_DATA_IDX = 2'h2;
  localparam int FLAG_BIT = 7;
  localparam int START_BIT = 5;
  localparam int STOP_BIT = 4;
  localparam int EN_BIT = 2;
  localparam logic [7:0] STAT_MASK = 8'hF8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_BYTE_ACK = 8'h28;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // ****************
  // Host registers
  // ****************
  localparam logic [3:0] HOST_CMD_OFS = 4'h0;
  localparam logic [3:0] HOST_ADDR_OFS = 4'h4;
  localparam logic [3:0] HOST_DATA_OFS = 4'h8;
  localparam logic [3:0] HOST_STAT_OFS = 4'hC;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_HELD_BIT = 3;
  localparam int ST_CODE_LSB = 8;
endpackage

// ### rtl/twh_host.sv
// Host sequencer writing one byte through the two-wire port registers
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module twh_host (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Async reset, low
  input wire logic hsel_in, // AHB select
  input wire logic [31:0] haddr_in, // AHB address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write
  input wire logic [2:0] hsize_in, // AHB size, word only
  input wire logic hready_in, // AHB ready in
  input wire logic [31:0] hwdata_in, // AHB write data
  output logic [31:0] hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB ready out
  output logic hresp_out, // AHB response
  output logic dev_req_out, // Port access request
  output logic dev_wr_out, // Port access is write
  output logic [1:0] dev_addr_out, // Port register index
  output logic [7:0] dev_wdata_out, // Port write data
  input wire logic dev_ack_in, // Port access acknowledge
  input wire logic [7:0] dev_rdata_in // Port read data
);
  import twh_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_START, S_POLL, S_STAT, S_LOAD, S_GO, S_STOP} twh_state_type;

  twh_state_type state_ff;
  logic ack_m_ff, ack_s_ff;
  logic [7:0] rd_m_ff, rd_s_ff, rd_cap_ff;
  logic [1:0] acc_ph_ff, step_ff;
  logic acc_done_ff, launch;
  logic op_wr;
  logic [1:0] op_addr;
  logic [7:0] op_data, masked, expect_code;
  logic wr_pend_ff, go_ff, stop_end_ff, busy_ff, done_ff, err_ff, held_ff, flag_seen_ff;
  logic [3:0] wr_ofs_ff;
  logic [6:0] tgt_addr_ff;
  logic [7:0] tx_byte_ff, code_ff;
  logic addr_ph;

  function automatic logic [7:0] ctrl_val(input logic start, input logic stop);
    ctrl_val = 8'h00;
    ctrl_val[FLAG_BIT] = 1'b1;
    ctrl_val[EN_BIT] = 1'b1;
    ctrl_val[START_BIT] = start;
    ctrl_val[STOP_BIT] = stop;
  endfunction

  // ****************
  // Synchronisers
  // ****************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_m_ff <= 1'b0;
      ack_s_ff <= 1'b0;
      rd_m_ff <= 8'h00;
      rd_s_ff <= 8'h00;
    end else begin
      ack_m_ff <= dev_ack_in;
      ack_s_ff <= ack_m_ff;
      rd_m_ff <= dev_rdata_in;
      rd_s_ff <= rd_m_ff;
    end
  end

  // ****************
  // AHB-Lite slave
  // ****************
  assign addr_ph = hsel_in && htrans_in[1] && hready_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff <= 4'h0;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend_ff <= addr_ph && hwrite_in;
      if (addr_ph) begin
        wr_ofs_ff <= haddr_in[3:0];
      end
      if (addr_ph && !hwrite_in) begin
        unique case ({haddr_in[3:2], 2'b00})
          HOST_CMD_OFS: hrdata_out <= {30'h0, stop_end_ff, 1'b0};
          HOST_ADDR_OFS: hrdata_out <= {25'h0, tgt_addr_ff};
          HOST_DATA_OFS: hrdata_out <= {24'h0, tx_byte_ff};
          HOST_STAT_OFS: hrdata_out <= {16'h0, code_ff, 4'h0, held_ff, err_ff, done_ff, busy_ff};
        endcase
      end
    end
  end

  // Setup registers, writes ignored while busy
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgt_addr_ff <= 7'h00;
      tx_byte_ff <= 8'h00;
      stop_end_ff <= 1'b1;
      go_ff <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (wr_pend_ff && !busy_ff) begin
        unique case ({wr_ofs_ff[3:2], 2'b00})
          HOST_CMD_OFS: begin
            stop_end_ff <= hwdata_in[CMD_STOP_BIT];
            go_ff <= hwdata_in[CMD_GO_BIT];
          end
          HOST_ADDR_OFS: tgt_addr_ff <= hwdata_in[6:0];
          HOST_DATA_OFS: tx_byte_ff <= hwdata_in[7:0]; // see R9
          HOST_STAT_OFS: ;
        endcase
      end
    end
  end

  // ****************
  // Port access engine
  // ****************
  always_comb begin
    op_wr = 1'b1;
    op_addr = DEV_CTRL_IDX;
    op_data = ctrl_val(1'b0, 1'b0); // see R15
    unique case (state_ff)
      S_IDLE: ;
      S_START: op_data = ctrl_val(1'b1, 1'b0);
      S_POLL: op_wr = 1'b0;
      S_STAT: begin
        op_wr = 1'b0;
        op_addr = DEV_STAT_IDX;
      end
      S_LOAD: begin
        op_addr = DEV_DATA_IDX;
        op_data = (step_ff == 2'd0) ? {tgt_addr_ff, DIR_WRITE} : tx_byte_ff; // see R5 R6
      end
      S_GO: ;
      S_STOP: op_data = ctrl_val(1'b0, 1'b1); // see R17
    endcase
  end

  assign launch = (state_ff != S_IDLE) && (acc_ph_ff == 2'd0) && !acc_done_ff;

  // Four-phase request and acknowledge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_ph_ff <= 2'd0;
      acc_done_ff <= 1'b0;
      dev_req_out <= 1'b0;
      dev_wr_out <= 1'b0;
      dev_addr_out <= 2'h0;
      dev_wdata_out <= 8'h00;
      rd_cap_ff <= 8'h00;
    end else begin
      acc_done_ff <= 1'b0;
      unique case (acc_ph_ff)
        2'd0: if (launch) begin
          dev_req_out <= 1'b1;
          dev_wr_out <= op_wr;
          dev_addr_out <= op_addr;
          dev_wdata_out <= op_data;
          acc_ph_ff <= 2'd1;
        end
        2'd1: if (ack_s_ff) begin
          dev_req_out <= 1'b0;
          rd_cap_ff <= rd_s_ff;
          acc_ph_ff <= 2'd2;
        end
        2'd2: if (!ack_s_ff) begin
          acc_ph_ff <= 2'd0;
          acc_done_ff <= 1'b1;
        end
        default: acc_ph_ff <= 2'd0;
      endcase
    end
  end

  // ****************
  // Transfer sequencer
  // ****************
  assign masked = rd_cap_ff & STAT_MASK; // see R13

  always_comb begin
    unique case (step_ff)
      2'd0: expect_code = held_ff ? CODE_RSTART : CODE_START;
      2'd1: expect_code = CODE_ADDR_ACK; // see R14
      default: expect_code = CODE_BYTE_ACK; // see R7
    endcase
  end

  // Only master transmit is issued; other modes are left to software
  always_ff @(posedge clk_in or negedge rst_n_in) begin // see R4
    if (!rst_n_in) begin
      state_ff <= S_IDLE;
      step_ff <= 2'd0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      held_ff <= 1'b0;
      code_ff <= 8'h00;
    end else if (state_ff == S_IDLE) begin
      if (go_ff) begin
        state_ff <= S_START;
        step_ff <= 2'd0;
        busy_ff <= 1'b1;
        done_ff <= 1'b0;
        err_ff <= 1'b0;
      end
    end else if (acc_done_ff) begin
      unique case (state_ff)
        S_START: state_ff <= S_POLL;
        S_POLL: if (rd_cap_ff[FLAG_BIT]) begin
          state_ff <= S_STAT;
        end
        S_STAT: begin
          code_ff <= masked;
          if (masked != expect_code) begin // see R8
            err_ff <= 1'b1;
            state_ff <= S_STOP;
          end else if (step_ff != 2'd2) begin
            state_ff <= S_LOAD; // see R12
          end else if (stop_end_ff) begin
            state_ff <= S_STOP;
          end else begin
            held_ff <= 1'b1;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_LOAD: state_ff <= S_GO;
        S_GO: begin
          step_ff <= step_ff + 2'd1;
          state_ff <= S_POLL;
        end
        S_STOP: begin
          held_ff <= 1'b0;
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          state_ff <= S_IDLE;
        end
        S_IDLE: ;
      endcase
    end
  end

  // Flag last seen set and not yet cleared by us
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_seen_ff <= 1'b0;
    end else if (state_ff == S_POLL && acc_done_ff && rd_cap_ff[FLAG_BIT]) begin
      flag_seen_ff <= 1'b1;
    end else if (launch && op_wr && op_addr == DEV_CTRL_IDX) begin
      flag_seen_ff <= 1'b0;
    end
  end

  // ****************
  // Assertions
  // ****************
  sequence s_data_wr;
    $rose(dev_req_out) && dev_wr_out && dev_addr_out == DEV_DATA_IDX;
  endsequence
  sequence s_ctrl_wr;
    $rose(dev_req_out) && dev_wr_out && dev_addr_out == DEV_CTRL_IDX;
  endsequence

  property p_dir_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_data_wr and (step_ff == 2'd0) |-> dev_wdata_out[0] == DIR_WRITE;
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("address sent without write direction"); // see R5 R6

  property p_load_when_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_data_wr |-> flag_seen_ff;
  endproperty
  a_load_when_flag: assert property (p_load_when_flag) else $error("data loaded with flag low"); // see R12

  property p_ctrl_bits;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_ctrl_wr |-> dev_wdata_out[FLAG_BIT] && dev_wdata_out[EN_BIT];
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control write lacks flag or enable"); // see R15

  property p_stop_seq;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_ctrl_wr and (state_ff == S_STOP) |-> dev_wdata_out[STOP_BIT] && !dev_wdata_out[START_BIT];
  endproperty
  a_stop_seq: assert property (p_stop_seq) else $error("stop write malformed"); // see R17

  property p_code_masked;
    @(posedge clk_in) disable iff (!rst_n_in)
      code_ff[2:0] == 3'h0;
  endproperty
  a_code_masked: assert property (p_code_masked) else $error("status code not masked"); // see R13

  property p_addr_err;
    @(posedge clk_in) disable iff (!rst_n_in)
      state_ff == S_STAT && acc_done_ff && step_ff == 2'd1 && masked != CODE_ADDR_ACK
      |=> err_ff && state_ff == S_STOP ##1 dev_req_out [*1];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address nack not treated as error"); // see R14

  property p_byte_ack;
    @(posedge clk_in) disable iff (!rst_n_in)
      state_ff == S_STAT && acc_done_ff && step_ff == 2'd2 && masked == CODE_BYTE_ACK
      |=> !err_ff && done_ff != stop_end_ff;
  endproperty
  a_byte_ack: assert property (p_byte_ack) else $error("acked byte mishandled"); // see R7

  property p_req_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      dev_req_out && !ack_s_ff |=> dev_req_out && $stable(dev_wdata_out) && $stable(dev_addr_out);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before acknowledge"); // see R9
endmodule // twh_host

// ### verification/twh_dev_model.sv
// Behavioural model of the two-wire port behind the host sequencer
`timescale 1ns/1ps
module twh_dev_model (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Async reset, low
  input wire logic dev_req_in, // Access request
  input wire logic dev_wr_in, // Access is write
  input wire logic [1:0] dev_addr_in, // Register index
  input wire logic [7:0] dev_wdata_in, // Write data
  output logic dev_ack_out, // Access acknowledge
  output logic [7:0] dev_rdata_out, // Read data
  input wire logic [2:0] delay_in, // Answer delay
  input wire logic nack_addr_in, // Refuse address byte
  input wire logic nack_data_in // Refuse data byte
);
  import twh_pkg::*;
  // ****************
  // Port state and handshake
  // ****************
  localparam int BYTE_CYC = 24;
  localparam logic [1:0] PRESC = 2'h3;
  logic flag_ff, coll_ff, en_ff, held_ff, start_ff, idx_ff;
  logic [7:0] code_ff, data_ff;
  logic [7:0] sent_q[$];
  logic [2:0] dly_ff;
  int run_ff, stops = 0;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_ff <= 1'b0;
      coll_ff <= 1'b0;
      en_ff <= 1'b0;
      held_ff <= 1'b0;
      start_ff <= 1'b0;
      idx_ff <= 1'b0;
      code_ff <= 8'hF8;
      data_ff <= 8'h00;
      run_ff <= 0;
      dly_ff <= 3'h0;
      dev_ack_out <= 1'b0;
      dev_rdata_out <= 8'h00;
    end else begin
      if (run_ff == 1) begin
        flag_ff <= 1'b1;
        if (start_ff) begin
          code_ff <= held_ff ? CODE_RSTART : CODE_START;
          held_ff <= 1'b1;
          idx_ff <= 1'b0;
        end else if (!idx_ff) begin
          code_ff <= nack_addr_in ? 8'h20 : CODE_ADDR_ACK;
          idx_ff <= 1'b1;
        end else begin
          code_ff <= nack_data_in ? 8'h30 : CODE_BYTE_ACK;
        end
      end
      if (run_ff != 0) run_ff <= run_ff - 1;
      if (dev_ack_out) begin
        if (!dev_req_in) begin
          dev_ack_out <= 1'b0;
          dev_rdata_out <= ~dev_rdata_out;
        end
      end else if (dev_req_in && dly_ff < delay_in) begin
        dly_ff <= dly_ff + 3'h1;
      end else if (dev_req_in) begin
        dly_ff <= 3'h0;
        dev_ack_out <= 1'b1;
        if (dev_addr_in == DEV_STAT_IDX) begin
          dev_rdata_out <= {code_ff[7:3], 1'b0, PRESC};
        end else if (dev_addr_in == DEV_DATA_IDX && dev_wr_in) begin
          if (flag_ff) data_ff <= dev_wdata_in;
          else coll_ff <= 1'b1;
        end else if (dev_addr_in == DEV_DATA_IDX) begin
          dev_rdata_out <= data_ff;
        end else if (!dev_wr_in) begin
          dev_rdata_out <= {flag_ff, 3'h0, coll_ff, en_ff, 2'h0};
        end else begin
          en_ff <= dev_wdata_in[EN_BIT];
          if (dev_wdata_in[FLAG_BIT] && dev_wdata_in[EN_BIT]) begin
            flag_ff <= 1'b0;
            code_ff <= 8'hF8;
            start_ff <= dev_wdata_in[START_BIT];
            if (dev_wdata_in[START_BIT]) begin
              run_ff <= BYTE_CYC;
            end else if (dev_wdata_in[STOP_BIT]) begin
              stops <= stops + 1;
              held_ff <= 1'b0;
            end else begin
              run_ff <= BYTE_CYC;
              sent_q.push_back(data_ff);
            end
          end
        end
      end
    end
  end
endmodule // twh_dev_model

// ### verification/testbench.sv
// Self-checking bench of the host sequencer against the port model
`timescale 1ns/1ps
module testbench;
  import twh_pkg::*;
  // ****************
  // Stimulus, checks and scenarios
  // ****************
  logic clk_in = 1'b0, rst_n_in = 1'b0, hwrite = 1'b0, nack_a = 1'b0, nack_d = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, lfsr_ff = 32'h000113BF, rd, hrdata;
  logic [1:0] htrans = 2'h0, dev_addr;
  logic [2:0] delay = 3'h0;
  logic hreadyout, hresp, dev_req, dev_wr, dev_ack;
  logic [7:0] dev_wdata, dev_rdata;
  int num_errors = 0, checks_done = 0, cycles = 0, stops_exp = 0, k;
  always #20 clk_in = ~clk_in;
  twh_host dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .dev_req_out(dev_req), .dev_wr_out(dev_wr),
    .dev_addr_out(dev_addr), .dev_wdata_out(dev_wdata), .dev_ack_in(dev_ack), .dev_rdata_in(dev_rdata));
  twh_dev_model port_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .dev_req_in(dev_req), .dev_wr_in(dev_wr),
    .dev_addr_in(dev_addr), .dev_wdata_in(dev_wdata), .dev_ack_out(dev_ack), .dev_rdata_out(dev_rdata),
    .delay_in(delay), .nack_addr_in(nack_a), .nack_data_in(nack_d));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_stat(input logic na, input logic nd, input logic stop);
    logic [7:0] code;
    code = na ? 8'h20 : (nd ? 8'h30 : CODE_BYTE_ACK);
    return {16'h0000, code, 4'h0, !(na | nd) && !stop, na | nd, 1'b1, 1'b0};
  endfunction
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] ofs, input logic [31:0] wd, output logic [31:0] rdv);
    haddr <= {28'h0, ofs};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic xfer(input logic [6:0] addr, input logic [7:0] data, input logic stop, input logic na,
    input logic nd);
    int n;
    logic [31:0] st;
    n = port_model.sent_q.size();
    nack_a <= na;
    nack_d <= nd;
    delay <= lfsr_ff[26:24];
    bus(1'b1, HOST_ADDR_OFS, {25'h0, addr}, st);
    bus(1'b1, HOST_DATA_OFS, {24'h0, data}, st);
    bus(1'b1, HOST_CMD_OFS, {30'h0, stop, 1'b1}, st);
    repeat (2) @(posedge clk_in);
    bus(1'b1, HOST_DATA_OFS, {24'h0, ~data}, st);
    bus(1'b0, HOST_STAT_OFS, 32'h0, st);
    chk("busy", {31'h0, st[ST_BUSY_BIT]}, 32'h1);
    while (st[ST_BUSY_BIT] !== 1'b0) bus(1'b0, HOST_STAT_OFS, 32'h0, st);
    if (na || nd || stop) stops_exp++;
    chk("status", st, exp_stat(na, nd, stop));
    chk("stops", port_model.stops, stops_exp);
    chk("address byte", {24'h0, port_model.sent_q[n]}, {24'h0, addr, DIR_WRITE});
    chk("bytes", 32'(port_model.sent_q.size() - n), na ? 32'h1 : 32'h2);
    if (!na) chk("data byte", {24'h0, port_model.sent_q[n + 1]}, {24'h0, data});
    chk("collision", {31'h0, port_model.coll_ff}, 32'h0);
    bus(1'b0, HOST_DATA_OFS, 32'h0, st);
    chk("data kept", st, {24'h0, data});
    bus(1'b0, HOST_ADDR_OFS, 32'h0, st);
    chk("address kept", st, {25'h0, addr});
    $display("test done: addr %h data %h stop %b nacks %b%b", addr, data, stop, na, nd);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, HOST_CMD_OFS, 32'h0, rd);
    chk("command reset", rd, 32'h00000002);
    chk("response", {31'h0, hresp}, 32'h0);
    bus(1'b1, HOST_STAT_OFS, 32'hFFFFFFFF, rd);
    bus(1'b0, HOST_STAT_OFS, 32'h0, rd);
    chk("status reset", rd, 32'h0);
    $display("test done: reset values");
    xfer(7'h50, 8'hA5, 1'b1, 1'b0, 1'b0);
    xfer(7'h21, 8'h00, 1'b0, 1'b0, 1'b0);
    xfer(7'h7F, 8'hFF, 1'b1, 1'b0, 1'b0);
    xfer(7'h00, 8'h3C, 1'b1, 1'b1, 1'b0);
    xfer(7'h11, 8'hC3, 1'b0, 1'b0, 1'b1);
    for (k = 0; k < 8; k++) begin
      lfsr_ff = next_rand(lfsr_ff);
      xfer(lfsr_ff[6:0], lfsr_ff[14:7], lfsr_ff[15], lfsr_ff[20:18] == 3'h0, lfsr_ff[23:21] == 3'h0);
    end
    summarize();
  end
endmodule // testbench
